// file: logic/event_bus_router.sv
`timescale 1ns/1ps
`default_nettype none
`include "evroute_regs.svh"

module event_bus_router
    import evroute_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  srst_in,
    input  wire logic                  soft_reset_in,
    input  wire logic                  cfg_wr_in,
    input  wire logic [2:0]            cfg_sel_in,
    input  wire logic [7:0]            cfg_code_in,
    output logic                       cfg_ack_out,
    output logic                       cfg_refused_out,
    input  wire logic                  cmd_run_in,
    input  wire logic                  cmd_stop_in,
    input  wire logic                  first_event_input_in,
    input  wire logic                  second_event_input_in,
    input  wire logic [2:0]            shared_line_in,
    output logic [2:0]                 shared_line_out,
    output logic [2:0]                 shared_line_oe_out,
    output logic                       end_aux_output_one_out,
    output logic                       end_aux_output_two_out,
    input  wire logic                  head_unit_present_in,
    input  wire logic                  multidrop_attach_in,
    input  wire logic                  remote_setpoint_enable_in,
    input  wire logic [15:0]           device_status_in,
    input  wire logic [3*NUM_CH-1:0]   alarm_in,
    input  wire logic [NUM_CH-1:0]     input_error_in,
    input  wire logic [NUM_CH-1:0]     remote_setpoint_error_in,
    input  wire logic [NUM_CH-1:0]     heater_burnout_alarm_in,
    input  wire logic [NUM_CH-1:0]     heater_short_alarm_in,
    input  wire logic [NUM_CH-1:0]     heater_overcurrent_alarm_in,
    output logic [NUM_CH-1:0]          run_out,
    output logic [NUM_CH-1:0]          manual_out,
    output logic [NUM_CH-1:0]          remote_setpoint_out,
    output logic [2*NUM_CH-1:0]        bank_out
);
    import evroute_pkg::*;

    localparam logic [2:0] NCH     = 3'(NUM_CH);
    localparam logic [7:0] IN_MAX  = (NUM_CH > 2) ? `IN_CODE_MAX_4CH : `IN_CODE_MAX_2CH;
    localparam logic [7:0] OUT_MAX = (NUM_CH > 2) ? `OUT_CODE_MAX_4CH : `OUT_CODE_MAX_2CH;

    // ------------------------------------------------------------------------
    // Assignment storage: written copy and active copy
    // ------------------------------------------------------------------------
    logic [7:0] pend_q [8];
    logic [7:0] pend_d [8];
    logic [7:0] act_q  [8];
    logic [7:0] act_d  [8];
    logic       ack_q, ack_d, ref_q, ref_d, init_q, init_d;
    logic [3:0] run_q, run_d, man_q, man_d, rem_q, rem_d;
    logic [1:0] bank_q [4];
    logic [1:0] bank_d [4];
    logic [4:0] prev_q, prev_d, lvl;
    logic [2:0] drive_q, drive_d;
    logic [1:0] aux_q, aux_d;
    logic       all_stopped;

    // Writes are judged on the registered run state; a write in the cycle of a run command is still taken.
    assign all_stopped = ~|run_q;

    always_comb begin
        pend_d = pend_q;
        act_d  = act_q;
        ack_d  = 1'b0;
        ref_d  = 1'b0;
        init_d = 1'b0;
        if (cfg_wr_in) begin
            if (all_stopped) begin
                pend_d[cfg_sel_in] = cfg_code_in;
                ack_d              = 1'b1;
            end else begin
                // A refused write leaves the written copy untouched.
                ref_d = 1'b1;
            end
        end
        // New codes only go live at a software reset; the startup pass then re-applies levels.
        if (soft_reset_in) begin
            act_d  = pend_d;
            init_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < 8; i++) begin
                pend_q[i] <= `CODE_DEFAULT;
                act_q[i]  <= `CODE_DEFAULT;
            end
            ack_q  <= 1'b0;
            ref_q  <= 1'b0;
            init_q <= 1'b1;
        end else begin
            pend_q <= pend_d;
            act_q  <= act_d;
            ack_q  <= ack_d;
            ref_q  <= ref_d;
            init_q <= init_d;
        end
    end

    // ------------------------------------------------------------------------
    // Input side: event inputs and shared lines steer channel state
    // ------------------------------------------------------------------------
    // Lines are read from the pin, so a level this unit drives is seen too.
    assign lvl = {shared_line_in, second_event_input_in, first_event_input_in};

    always_comb begin
        in_dec_t d;
        logic    allowed;
        d       = '0;
        allowed = 1'b0;
        run_d   = run_q;
        man_d   = man_q;
        rem_d   = rem_q;
        bank_d  = bank_q;
        prev_d  = lvl;
        // Run and stop commands reach every fitted channel; event and line sources below may override them.
        if (cmd_run_in) begin
            for (int c = 0; c < NUM_CH; c++) begin
                run_d[c] = 1'b1;
            end
        end
        if (cmd_stop_in) begin
            run_d = 4'h0;
        end
        // Later sources override earlier ones; keeping units free of conflicts is software's job.
        for (int i = 0; i < 5; i++) begin
            d       = decode_in(act_q[i], IN_MAX, NCH);
            // Event inputs always count; shared lines need a head unit and a direct link.
            allowed = (i < 2) || (head_unit_present_in && !multidrop_attach_in);
            if (allowed && (init_q || lvl[i] != prev_q[i])) begin
                for (int c = 0; c < 4; c++) begin
                    if (c < NUM_CH && (d.all_ch || d.ch == 2'(c))) begin
                        case (d.func)
                            FN_BANK0:    bank_d[c][0] = lvl[i];
                            FN_BANK1:    bank_d[c][1] = lvl[i];
                            FN_STOP_RUN: run_d[c] = lvl[i];
                            FN_RUN_STOP: run_d[c] = ~lvl[i];
                            FN_AUTO_MAN: man_d[c] = lvl[i];
                            FN_LOC_REM: begin
                                if (remote_setpoint_enable_in) begin
                                    rem_d[c] = lvl[i];
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Channel state registers
    // ------------------------------------------------------------------------
    // Power-up clears the state; the startup pass that follows applies the input levels.
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            run_q  <= 4'h0;
            man_q  <= 4'h0;
            rem_q  <= 4'h0;
            prev_q <= 5'h00;
            for (int c = 0; c < 4; c++) begin
                bank_q[c] <= 2'b00;
            end
        end else begin
            run_q  <= run_d;
            man_q  <= man_d;
            rem_q  <= rem_d;
            prev_q <= prev_d;
            bank_q <= bank_d;
        end
    end

    // ------------------------------------------------------------------------
    // Output side: status sources onto the shared lines
    // ------------------------------------------------------------------------
    logic [15:0]          ch_src [4];
    logic [`OS_COUNT-1:0] all_src;

    generate
        for (genvar c = 0; c < 4; c++) begin : g_ch
            if (c < NUM_CH) begin : g_on
                logic [2:0] a;
                // Bit order follows the per-channel output code offsets, lowest first.
                assign a         = alarm_in[3*c +: 3];
                assign ch_src[c] = {rem_q[c], man_q[c], ~run_q[c], run_q[c], bank_q[c],
                                    heater_overcurrent_alarm_in[c], heater_short_alarm_in[c],
                                    heater_burnout_alarm_in[c], remote_setpoint_error_in[c],
                                    input_error_in[c], &a, |a, a};
            end else begin : g_off
                assign ch_src[c] = 16'h0000;
            end
        end
    endgenerate

    always_comb begin
        logic [NUM_CH-1:0] any;
        logic [2:0]        aor, aand;
        any  = '0;
        aor  = 3'b000;
        aand = 3'b111;
        // Any-alarm AND combines each channel's alarm OR, not the single alarm bits.
        for (int c = 0; c < NUM_CH; c++) begin
            any[c] = ch_src[c][`CHS_ALM_OR];
            aor    = aor | ch_src[c][2:0];
            aand   = aand & ch_src[c][2:0];
        end
        all_src                     = '0;
        all_src[`OS_CTL_ERR]        = |(device_status_in & `CTL_ERR_MASK);
        all_src[`OS_ANY_OR]         = |any;
        all_src[`OS_ANY_AND]        = &any;
        all_src[`OS_ALM_OR +: 3]    = aor;
        all_src[`OS_ALM_AND +: 3]   = aand;
        all_src[`OS_INERR]          = |input_error_in;
        all_src[`OS_RSPERR]         = |remote_setpoint_error_in;
        all_src[`OS_HB]             = |heater_burnout_alarm_in;
        all_src[`OS_HS]             = |heater_short_alarm_in;
        all_src[`OS_OC]             = |heater_overcurrent_alarm_in;
        all_src[`OS_EV +: 2]        = lvl[1:0];
        all_src[`OS_BUS +: 3]       = shared_line_in;
    end

    // ------------------------------------------------------------------------
    // Shared line drive selection
    // ------------------------------------------------------------------------
    // A code naming an absent channel decodes as disabled, so unfitted channel sources are never selected.
    always_comb begin
        out_dec_t o;
        o       = '0;
        drive_d = 3'b000;
        for (int l = 0; l < 3; l++) begin
            o = decode_out(act_q[`SEL_BUSOUT + 3'(l)], OUT_MAX, NCH);
            if (o.en) begin
                drive_d[l] = o.all_ch ? all_src[o.src] : ch_src[o.ch][o.src[3:0]];
            end
        end
        // The end unit's auxiliary outputs copy resolved lines one and two (not line three), whoever drives them.
        aux_d = shared_line_in[1:0];
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            drive_q <= 3'b000;
            aux_q   <= 2'b00;
        end else begin
            drive_q <= drive_d;
            aux_q   <= aux_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Lines are wired-OR: a unit only ever pulls high, so several drivers never fight.
    assign shared_line_out        = drive_q;
    assign shared_line_oe_out     = drive_q;
    assign end_aux_output_one_out = aux_q[0];
    assign end_aux_output_two_out = aux_q[1];
    assign cfg_ack_out            = ack_q;
    assign cfg_refused_out        = ref_q;

    // Channels beyond NUM_CH keep their state bits at zero and have no output bits.
    generate
        for (genvar c = 0; c < NUM_CH; c++) begin : g_out
            assign run_out[c]             = run_q[c];
            assign manual_out[c]          = man_q[c];
            assign remote_setpoint_out[c] = rem_q[c];
            assign bank_out[2*c +: 2]     = bank_q[c];
        end
    endgenerate

endmodule

`default_nettype wire

// file: logic/evroute_regs.svh
`ifndef EVROUTE_REGS_SVH
`define EVROUTE_REGS_SVH

// ----------------------------------------------------------------------------
// Assignment code ranges per unit variant
// ----------------------------------------------------------------------------
`define IN_CODE_MAX_2CH   8'h45
`define IN_CODE_MAX_4CH   8'h84
`define OUT_CODE_MAX_2CH  8'h57
`define OUT_CODE_MAX_4CH  8'h96
`define CODE_DEFAULT      8'h00

// ----------------------------------------------------------------------------
// Input assignment code layout
// ----------------------------------------------------------------------------
`define IN_ALL_LAST       8'h06
`define IN_CH_BASE        8'h14
`define IN_CH_STRIDE      8'h14

// ----------------------------------------------------------------------------
// Output assignment code layout
// ----------------------------------------------------------------------------
`define OUT_ALL_LAST      8'h15
`define OUT_CH_BASE       8'h20
`define OUT_CH_STRIDE     8'h18
`define OUT_CH_LAST       8'h0f

// ----------------------------------------------------------------------------
// All-channel output source indices
// ----------------------------------------------------------------------------
`define OS_CTL_ERR        5'h01
`define OS_ANY_OR         5'h02
`define OS_ANY_AND        5'h03
`define OS_ALM_OR         5'h04
`define OS_ALM_AND        5'h07
`define OS_INERR          5'h0a
`define OS_RSPERR         5'h0b
`define OS_HB             5'h0c
`define OS_HS             5'h0d
`define OS_OC             5'h0e
`define OS_EV             5'h0f
`define OS_BUS            5'h13
`define OS_COUNT          22

// ----------------------------------------------------------------------------
// Misc
// ----------------------------------------------------------------------------
`define CTL_ERR_MASK      16'h3fff
`define SEL_BUSIN         3'h2
`define SEL_BUSOUT        3'h5
`define CHS_ALM_OR        4'h3

`endif

// file: logic/evroute_pkg.sv
package evroute_pkg;
`include "evroute_regs.svh"

    typedef enum logic [2:0] {
        FN_OFF      = 3'b000,
        FN_BANK0    = 3'b001,
        FN_BANK1    = 3'b010,
        FN_STOP_RUN = 3'b011,
        FN_RUN_STOP = 3'b100,
        FN_AUTO_MAN = 3'b101,
        FN_LOC_REM  = 3'b110
    } in_func_t;

    typedef struct packed {
        in_func_t   func;
        logic       all_ch;
        logic [1:0] ch;
    } in_dec_t;

    typedef struct packed {
        logic       en;
        logic       all_ch;
        logic [1:0] ch;
        logic [4:0] src;
    } out_dec_t;

    // Codes past the variant's maximum, or naming an absent channel, read as disabled.
    function automatic in_dec_t decode_in(input logic [7:0] code, input logic [7:0] max_code,
                                          input logic [2:0] nch);
        in_dec_t    d;
        logic [7:0] base;
        d.func   = FN_OFF;
        d.all_ch = 1'b0;
        d.ch     = 2'b00;
        base     = 8'h00;
        if (code <= max_code) begin
            if (code <= `IN_ALL_LAST) begin
                d.all_ch = 1'b1;
                d.func   = in_func_t'(code[2:0]);
            end
            for (int c = 0; c < 4; c++) begin
                base = 8'(`IN_CH_BASE + `IN_CH_STRIDE * c);
                if (c < nch && code >= base && code <= 8'(base + `IN_ALL_LAST) && code != base) begin
                    d.ch   = 2'(c);
                    d.func = in_func_t'(3'(code - base));
                end
            end
        end
        return d;
    endfunction

    function automatic out_dec_t decode_out(input logic [7:0] code, input logic [7:0] max_code,
                                            input logic [2:0] nch);
        out_dec_t   d;
        logic [7:0] base;
        d.en     = 1'b0;
        d.all_ch = 1'b0;
        d.ch     = 2'b00;
        d.src    = 5'h00;
        base     = 8'h00;
        if (code <= max_code) begin
            if (code != `CODE_DEFAULT && code <= `OUT_ALL_LAST) begin
                d.en     = 1'b1;
                d.all_ch = 1'b1;
                d.src    = code[4:0];
            end
            for (int c = 0; c < 4; c++) begin
                base = 8'(`OUT_CH_BASE + `OUT_CH_STRIDE * c);
                if (c < nch && code >= base && code <= 8'(base + `OUT_CH_LAST)) begin
                    d.en  = 1'b1;
                    d.ch  = 2'(c);
                    d.src = 5'(code - base);
                end
            end
        end
        return d;
    endfunction

endpackage

// file: verification/event_bus_router_chk.sv
`timescale 1ns/1ps
`default_nettype none
module event_bus_router_chk #(
    parameter int NUM_CH = 2
) (
    input wire logic                core_clk_in,
    input wire logic                srst_in,
    input wire logic                cfg_wr_in,
    input wire logic [2:0]          cfg_sel_in,
    input wire logic [7:0]          cfg_code_in,
    input wire logic                cfg_ack_out,
    input wire logic                cfg_refused_out,
    input wire logic [2:0]          shared_line_in,
    input wire logic [2:0]          shared_line_out,
    input wire logic [2:0]          shared_line_oe_out,
    input wire logic                end_aux_output_one_out,
    input wire logic                end_aux_output_two_out,
    input wire logic                remote_setpoint_enable_in,
    input wire logic [NUM_CH-1:0]   run_out,
    input wire logic [NUM_CH-1:0]   remote_setpoint_out,
    input wire logic [2*NUM_CH-1:0] bank_out
);
    // Conservative: any non-zero output code written since reset may enable driving.
    logic out_cfg_d;
    logic out_cfg_q;
    always_comb out_cfg_d = out_cfg_q | (cfg_wr_in && cfg_sel_in >= 3'h5 && cfg_code_in != 8'h00);
    always_ff @(posedge core_clk_in) out_cfg_q <= srst_in ? 1'b0 : out_cfg_d;

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    chk_write_accepted: assert property (cfg_wr_in && run_out == '0 |=> cfg_ack_out && !cfg_refused_out)
        else $error("write while stopped was not acknowledged");
    chk_write_refused: assert property (cfg_wr_in && run_out != '0 |=> cfg_refused_out && !cfg_ack_out)
        else $error("write while running was not refused");
    chk_answer_origin: assert property (cfg_ack_out || cfg_refused_out |-> $past(cfg_wr_in))
        else $error("config answer without a write");
    chk_aux_one: assert property (!$past(srst_in) |-> end_aux_output_one_out == $past(shared_line_in[0]))
        else $error("aux output one does not follow shared line one");
    chk_aux_two: assert property (!$past(srst_in) |-> end_aux_output_two_out == $past(shared_line_in[1]))
        else $error("aux output two does not follow shared line two");
    chk_drive_match: assert property (shared_line_out == shared_line_oe_out)
        else $error("shared line data and enable differ");
    chk_reset_clear: assert property ($fell(srst_in) |-> run_out == '0 && bank_out == '0 && shared_line_oe_out == 3'h0)
        else $error("outputs not cleared by reset");
    chk_idle_lines: assert property (!out_cfg_q |-> shared_line_oe_out == 3'h0)
        else $error("shared line driven with default codes");
    chk_remote_gate: assert property ($rose(remote_setpoint_out[0]) |-> $past(remote_setpoint_enable_in))
        else $error("remote set point taken while disabled");
endmodule
bind event_bus_router event_bus_router_chk #(.NUM_CH(NUM_CH)) u_chk (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .cfg_wr_in(cfg_wr_in), .cfg_sel_in(cfg_sel_in),
    .cfg_code_in(cfg_code_in), .cfg_ack_out(cfg_ack_out), .cfg_refused_out(cfg_refused_out),
    .shared_line_in(shared_line_in), .shared_line_out(shared_line_out), .shared_line_oe_out(shared_line_oe_out),
    .end_aux_output_one_out(end_aux_output_one_out), .end_aux_output_two_out(end_aux_output_two_out),
    .remote_setpoint_enable_in(remote_setpoint_enable_in), .run_out(run_out),
    .remote_setpoint_out(remote_setpoint_out), .bank_out(bank_out));
`default_nettype wire

// file: verification/contact_bank_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands for the field contacts and one linked unit on the shared lines.
module contact_bank_model (
    input  wire logic [1:0] contact_in,
    input  wire logic [2:0] peer_drive_in,
    input  wire logic [2:0] unit_line_in,
    input  wire logic [2:0] unit_oe_in,
    output logic            first_event_input_out,
    output logic            second_event_input_out,
    output logic [2:0]      shared_line_out
);
    assign first_event_input_out  = contact_in[0];
    assign second_event_input_out = contact_in[1];
    // Wired-OR with pull-down: an undriven line reads low, and the driver sees its own level.
    assign shared_line_out = (unit_line_in & unit_oe_in) | peer_drive_in;
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        core_clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic        soft_reset_in = 1'b0;
    logic        cfg_wr_in = 1'b0;
    logic [2:0]  cfg_sel_in = 3'h0;
    logic [7:0]  cfg_code_in = 8'h00;
    logic        cmd_run_in = 1'b0;
    logic        cmd_stop_in = 1'b0;
    logic [1:0]  contact = 2'b00;
    logic [2:0]  peer = 3'h0;
    logic        head = 1'b1;
    logic        multi = 1'b0;
    logic        rsp_en = 1'b1;
    logic [15:0] status = 16'h0000;
    logic [5:0]  alarm = 6'h00;
    logic [9:0]  faults = 10'h000;
    logic [5:0]  exp6;
    logic [2:0]  exp3;
    wire logic       ev1, ev2, ack, refused, aux1, aux2;
    wire logic [2:0] line, line_out, line_oe;
    wire logic [1:0] run, man, rem;
    wire logic [3:0] bank;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int codes[$] = '{3, 4, 5, 6, 6, 23, 43, 24, 45, 63, 70};

    always #5 core_clk_in = ~core_clk_in;

    contact_bank_model partner (.contact_in(contact), .peer_drive_in(peer), .unit_line_in(line_out),
        .unit_oe_in(line_oe), .first_event_input_out(ev1), .second_event_input_out(ev2), .shared_line_out(line));

    event_bus_router #(.NUM_CH(2)) dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .soft_reset_in(soft_reset_in),
        .cfg_wr_in(cfg_wr_in), .cfg_sel_in(cfg_sel_in), .cfg_code_in(cfg_code_in), .cfg_ack_out(ack),
        .cfg_refused_out(refused), .cmd_run_in(cmd_run_in), .cmd_stop_in(cmd_stop_in),
        .first_event_input_in(ev1), .second_event_input_in(ev2), .shared_line_in(line),
        .shared_line_out(line_out), .shared_line_oe_out(line_oe), .end_aux_output_one_out(aux1),
        .end_aux_output_two_out(aux2), .head_unit_present_in(head), .multidrop_attach_in(multi),
        .remote_setpoint_enable_in(rsp_en), .device_status_in(status), .alarm_in(alarm),
        .input_error_in(faults[1:0]), .remote_setpoint_error_in(faults[3:2]), .heater_burnout_alarm_in(faults[5:4]),
        .heater_short_alarm_in(faults[7:6]), .heater_overcurrent_alarm_in(faults[9:8]), .run_out(run),
        .manual_out(man), .remote_setpoint_out(rem), .bank_out(bank));

    // ------------
    // Helpers
    // ------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask

    task automatic cfg(input logic [2:0] sel, input logic [7:0] code, input logic refuse);
        cfg_wr_in = 1'b1;
        cfg_sel_in = sel;
        cfg_code_in = code;
        cyc(1);
        check(8'({refused, ack}), 8'({refuse, !refuse}), "config answer");
        cfg_wr_in = 1'b0;
        cyc(1);
    endtask

    task automatic soft_reset();
        soft_reset_in = 1'b1;
        cyc(1);
        soft_reset_in = 1'b0;
        cyc(3);
    endtask

    task automatic pulse_cmd(input logic do_run, input logic do_stop);
        cmd_run_in = do_run;
        cmd_stop_in = do_stop;
        cyc(1);
        cmd_run_in = 1'b0;
        cmd_stop_in = 1'b0;
        cyc(2);
    endtask

    // Expected {remote, manual, run} for one assignment code at a contact level.
    function automatic logic [5:0] model(input int code, input logic lvl, input logic en);
        int f;
        logic [1:0] m;
        f = (code <= 6) ? code : code % 20;
        m = (code <= 6) ? 2'b11 : (code > 20 && code < 27) ? 2'b01 : (code > 40 && code < 47) ? 2'b10 : 2'b00;
        if (f == 6 && !en) m = 2'b00;
        case (f)
            3: return {4'h0, m & {2{lvl}}};
            4: return {4'h0, m & {2{!lvl}}};
            5: return {2'b00, m & {2{lvl}}, 2'b00};
            6: return {m & {2{lvl}}, 4'h0};
            default: return 6'h00;
        endcase
    endfunction

    // ------------
    // Sequence
    // ------------
    initial begin
        void'($urandom(47));
        cyc(12);
        srst_in = 1'b0;
        cyc(1);
        check(8'({line_oe, run}), 8'h00, "reset values");
        check(8'(bank), 8'h00, "reset bank");
        // Each code is tried on alternating event inputs with the other one disabled.
        foreach (codes[i]) begin
            rsp_en = (i != 4);
            cfg(3'(i % 2), 8'(codes[i]), 1'b0);
            cfg(3'((i + 1) % 2), 8'h00, 1'b0);
            soft_reset();
            exp6 = model(codes[i], 1'b0, rsp_en);
            check(8'({rem, man, run}), 8'(exp6), "startup level");
            if (exp6[1:0] != 2'b00) cfg(3'(i % 2), 8'h00, 1'b1);
            for (int l = 1; l >= 0; l--) begin
                contact[i % 2] = l[0];
                cyc(3);
                check(8'({rem, man, run}), 8'(model(codes[i], l[0], rsp_en)), "level follow");
            end
            pulse_cmd(1'b0, 1'b1);
        end
        cfg(3'h0, 8'h01, 1'b0);
        cfg(3'h1, 8'h02, 1'b0);
        soft_reset();
        for (int b = 0; b < 4; b++) begin
            contact = 2'(b);
            cyc(3);
            check(8'(bank), 8'({2{2'(b)}}), "bank select");
        end
        contact = 2'b00;
        cfg(3'h0, 8'h00, 1'b0);
        cfg(3'h1, 8'h00, 1'b0);
        for (int s = 2; s < 8; s++) begin
            cfg(3'(s), 8'h00, 1'b0);
        end
        cfg(3'h5, 8'h01, 1'b0);
        cfg(3'h6, 8'h04, 1'b0);
        cfg(3'h7, 8'h03, 1'b0);
        soft_reset();
        repeat (8) begin
            status = 16'($urandom) & ($urandom_range(1) ? 16'hffff : 16'hc000);
            alarm = 6'($urandom);
            faults = 10'($urandom);
            cyc(3);
            exp3 = {(|alarm[2:0]) & (|alarm[5:3]), alarm[0] | alarm[3], |status[13:0]};
            check(8'(line_out), 8'(exp3), "bus drive");
            check(8'(line_oe), 8'(exp3), "bus enable");
            check(8'({aux2, aux1}), 8'(exp3[1:0]), "end aux");
        end
        status = 16'h0000;
        alarm = 6'h00;
        cfg(3'h2, 8'h03, 1'b0);
        soft_reset();
        for (int k = 0; k < 3; k++) begin
            head = (k != 1);
            multi = (k == 2);
            status = 16'h0001;
            cyc(4);
            check(8'(run), (k == 0) ? 8'h03 : 8'h00, "bus input");
            status = 16'h0000;
            cyc(4);
            check(8'(run), 8'h00, "bus input off");
        end
        head = 1'b1;
        multi = 1'b0;
        peer = 3'h1;
        cyc(4);
        check(8'(run), 8'h03, "peer drive");
        peer = 3'h0;
        cyc(4);
        pulse_cmd(1'b1, 1'b1);
        check(8'(run), 8'h00, "stop wins");
        pulse_cmd(1'b1, 1'b0);
        check(8'(run), 8'h03, "run command");
        // Line one now carries channel two's run state and is read back by the stop/run input.
        pulse_cmd(1'b0, 1'b1);
        cfg(3'h5, 8'h44, 1'b0);
        soft_reset();
        pulse_cmd(1'b1, 1'b0);
        check(8'({line_out[0], run}), 8'h07, "channel run drive");
        pulse_cmd(1'b0, 1'b1);
        check(8'({line_out[0], run}), 8'h00, "channel stop drive");
        complete_run();
    end
endmodule
`default_nettype wire
